// >>> verilog/bsp_pkg.sv
// Package: register map, field positions, reset values and timing constants of the brake sequencer
package bsp_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_SUBMODE   = 8'h00;  // drive_submode_select
    localparam logic [7:0] ADDR_DOUT      = 8'h04;  // digital_outputs_word subindex 1
    localparam logic [7:0] ADDR_OVR_EN    = 8'h08;  // output_control_settings manual enable
    localparam logic [7:0] ADDR_OVR_VAL   = 8'h0C;  // output_control_settings manual value
    localparam logic [7:0] ADDR_DLY_BASE  = 8'h10;  // brake_timing_params subindex 1..4
    localparam logic [7:0] ADDR_PWM_FREQ  = 8'h20;  // brake_timing_params subindex 5
    localparam logic [7:0] ADDR_PWM_DUTY  = 8'h24;  // brake_timing_params subindex 6
    localparam logic [7:0] ADDR_DRV_CTRL  = 8'h28;  // Operation enable request
    localparam logic [7:0] ADDR_STATUS    = 8'h2C;  // Sequencer state and outputs
    // Field positions
    localparam int unsigned BIT_AUTO_BRAKE = 2;
    localparam int unsigned BIT_BRAKE      = 0;
    // Limits and reset values
    localparam logic [15:0] FREQ_MAX       = 16'h07D0;  // 2000 Hz
    localparam logic [15:0] FREQ_MIN       = 16'h0001;
    localparam logic [7:0]  DUTY_MIN       = 8'h02;
    localparam logic [7:0]  DUTY_FULL      = 8'h64;     // 100 percent
    localparam logic [15:0] FREQ_RST       = 16'h07D0;
    localparam logic [7:0]  DUTY_RST       = 8'h64;
    // Delays are in milliseconds, counted by a 1 ms tick
    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned TICK_MS_CYC    = CLK_HZ / 1000;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;
    localparam logic [1:0]  RESP_DECERR    = 2'b11;
    typedef enum logic [2:0] {
        SEQ_IDLE    = 3'b000,
        SEQ_REL_DLY = 3'b001,
        SEQ_REL_HLD = 3'b010,
        SEQ_ENABLED = 3'b011,
        SEQ_ENG_DLY = 3'b100,
        SEQ_ENG_HLD = 3'b101
    } bsp_seq_e;
endpackage

// >>> verilog/bsp_pwm.sv
// Brake PWM generator: period from frequency, on-time from duty percentage
module bsp_pwm
    import bsp_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        enable_i,
    input  wire logic [15:0] freq_hz_i,
    input  wire logic [7:0]  duty_pct_i,
    output logic             pwm_o
);
    logic [31:0] period_q;
    logic [31:0] on_q;
    logic [31:0] cnt_q;
    logic        pwm_q;

    // Period and on-time recomputed each cycle; divider is slow but off the output path
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            period_q <= 32'h0000_0001;
            on_q     <= 32'h0000_0001;
        end else begin
            period_q <= 32'(CLK_HZ) / {16'h0000, freq_hz_i};
            on_q     <= (32'(CLK_HZ) / {16'h0000, freq_hz_i}) / 32'(DUTY_FULL)
                        * {24'h00_0000, duty_pct_i};
        end
    end

    // Period counter, held at zero while brake is off
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !enable_i) begin
            cnt_q <= 32'h0000_0000;
        end else if (cnt_q + 32'h0000_0001 >= period_q) begin
            cnt_q <= 32'h0000_0000;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end

    // Full duty holds output steady without pulses
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pwm_q <= 1'b0;
        end else if (!enable_i) begin
            pwm_q <= 1'b0;
        end else if (duty_pct_i == DUTY_FULL) begin
            pwm_q <= 1'b1;
        end else begin
            pwm_q <= (cnt_q < on_q);
        end
    end

    assign pwm_o = pwm_q;
endmodule

// >>> verilog/bsp_top.sv
// Brake sequencer top: AXI4-Lite registers, release/engage sequencing and brake output
module bsp_top
    import bsp_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Drive side
    input  wire logic        motor_standstill_i,
    output logic             motor_current_on_o,
    output logic             motor_stop_req_o,
    output logic             op_enabled_o,
    output logic             brake_out_o
);
    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [31:0] submode_q;
    logic [31:0] dout_q;
    logic [31:0] ovr_en_q;
    logic [31:0] ovr_val_q;
    logic [15:0] dly_q [4];
    logic [15:0] freq_q;
    logic [7:0]  duty_q;
    logic        op_req_q;
    logic        aw_held_q;
    logic        w_held_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic        wr_fire;
    logic        wr_ok;

    // Latch each write channel independently, accept in either order
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Full-word writes only keep the range checks simple; strobes are ignored
    function automatic logic addr_known(input logic [7:0] a);
        return (a <= ADDR_STATUS) && (a[1:0] == 2'b00);
    endfunction

    assign wr_ok = addr_known(awaddr_q) && !(awaddr_q == ADDR_STATUS);

    // Register writes with range checks on PWM settings
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            submode_q <= 32'h0000_0000;
            dout_q    <= 32'h0000_0000;
            ovr_en_q  <= 32'h0000_0000;
            ovr_val_q <= 32'h0000_0000;
            for (int i = 0; i < 4; i++) dly_q[i] <= 16'h0000;
            freq_q    <= FREQ_RST;
            duty_q    <= DUTY_RST;
            op_req_q  <= 1'b0;
        end else if (wr_fire) begin
            unique case (awaddr_q)
                ADDR_SUBMODE:  submode_q <= wdata_q;
                ADDR_DOUT:     dout_q    <= wdata_q;
                ADDR_OVR_EN:   ovr_en_q  <= wdata_q;
                ADDR_OVR_VAL:  ovr_val_q <= wdata_q;
                ADDR_PWM_FREQ: begin
                    if (wdata_q[31:16] == 16'h0000 && wdata_q[15:0] >= FREQ_MIN
                        && wdata_q[15:0] <= FREQ_MAX) begin
                        freq_q <= wdata_q[15:0];
                    end
                end
                ADDR_PWM_DUTY: begin
                    if (wdata_q[31:8] == 24'h00_0000 && wdata_q[7:0] >= DUTY_MIN
                        && wdata_q[7:0] <= DUTY_FULL) begin
                        duty_q <= wdata_q[7:0];
                    end
                end
                ADDR_DRV_CTRL: op_req_q <= wdata_q[0];
                default: begin
                    if (awaddr_q >= ADDR_DLY_BASE && awaddr_q < ADDR_PWM_FREQ) begin
                        dly_q[awaddr_q[3:2]] <= wdata_q[15:0];
                    end
                end
            endcase
        end
    end

    // Write response
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    bsp_seq_e    state_q;
    logic [15:0] ms_left_q;
    logic [31:0] tick_cnt_q;
    logic        tick;
    logic        auto_mode;
    logic        brake_on_auto;
    logic        brake_on;

    assign auto_mode = submode_q[BIT_AUTO_BRAKE];

    // Free-running millisecond tick; the first millisecond of a delay may be short
    assign tick = (tick_cnt_q == 32'(TICK_MS_CYC - 1));
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || tick) begin
            tick_cnt_q <= 32'h0000_0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        end
    end

    // Release and engage sequence; a zero delay moves on next cycle
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_q   <= SEQ_IDLE;
            ms_left_q <= 16'h0000;
        end else begin
            unique case (state_q)
                SEQ_IDLE: begin
                    if (op_req_q) begin
                        state_q   <= SEQ_REL_DLY;
                        ms_left_q <= dly_q[2];
                    end
                end
                SEQ_REL_DLY: begin
                    // Brake not yet opened: going via delay 1 would open it briefly
                    if (!op_req_q) begin
                        state_q   <= SEQ_ENG_HLD;
                        ms_left_q <= dly_q[1];
                    end else if (ms_left_q == 16'h0000) begin
                        state_q   <= SEQ_REL_HLD;
                        ms_left_q <= dly_q[3];
                    end else if (tick) begin
                        ms_left_q <= ms_left_q - 16'h0001;
                    end
                end
                SEQ_REL_HLD: begin
                    if (!op_req_q) begin
                        state_q   <= SEQ_ENG_DLY;
                        ms_left_q <= dly_q[0];
                    end else if (ms_left_q == 16'h0000) begin
                        state_q <= SEQ_ENABLED;
                    end else if (tick) begin
                        ms_left_q <= ms_left_q - 16'h0001;
                    end
                end
                SEQ_ENABLED: begin
                    if (!op_req_q) begin
                        state_q   <= SEQ_ENG_DLY;
                        ms_left_q <= dly_q[0];
                    end
                end
                SEQ_ENG_DLY: begin
                    // Delay 1 starts once the motor is at standstill
                    if (motor_standstill_i) begin
                        if (ms_left_q == 16'h0000) begin
                            state_q   <= SEQ_ENG_HLD;
                            ms_left_q <= dly_q[1];
                        end else if (tick) begin
                            ms_left_q <= ms_left_q - 16'h0001;
                        end
                    end
                end
                SEQ_ENG_HLD: begin
                    if (ms_left_q == 16'h0000) begin
                        state_q <= SEQ_IDLE;
                    end else if (tick) begin
                        ms_left_q <= ms_left_q - 16'h0001;
                    end
                end
                default: begin
                    state_q <= SEQ_IDLE;
                end
            endcase
        end
    end

    // Brake released only in the release hold step, the enabled state and the whole engage delay step, before and after standstill
    assign brake_on_auto = (state_q == SEQ_REL_HLD) || (state_q == SEQ_ENABLED)
                           || (state_q == SEQ_ENG_DLY);

    // Manual override beats auto and manual bit 0
    always_comb begin
        if (ovr_en_q[BIT_BRAKE]) begin
            brake_on = ovr_val_q[BIT_BRAKE];
        end else if (auto_mode) begin
            brake_on = brake_on_auto;
        end else begin
            brake_on = dout_q[BIT_BRAKE];
        end
    end

    // Drive status outputs from registered state
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            motor_current_on_o <= 1'b0;
            motor_stop_req_o   <= 1'b0;
            op_enabled_o       <= 1'b0;
        end else begin
            motor_current_on_o <= (state_q != SEQ_IDLE);
            motor_stop_req_o   <= (state_q == SEQ_ENG_DLY) || (state_q == SEQ_ENG_HLD);
            op_enabled_o       <= (state_q == SEQ_ENABLED);
        end
    end

    bsp_pwm u_pwm (
        .sys_clk_i  (sys_clk_i),
        .sys_rst_i  (sys_rst_i),
        .enable_i   (brake_on),
        .freq_hz_i  (freq_q),
        .duty_pct_i (duty_q),
        .pwm_o      (brake_out_o)
    );

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
            unique case (s_axi_araddr)
                ADDR_SUBMODE:  s_axi_rdata <= submode_q;
                ADDR_DOUT:     s_axi_rdata <= dout_q;
                ADDR_OVR_EN:   s_axi_rdata <= ovr_en_q;
                ADDR_OVR_VAL:  s_axi_rdata <= ovr_val_q;
                ADDR_PWM_FREQ: s_axi_rdata <= {16'h0000, freq_q};
                ADDR_PWM_DUTY: s_axi_rdata <= {24'h00_0000, duty_q};
                ADDR_DRV_CTRL: s_axi_rdata <= {31'h0000_0000, op_req_q};
                ADDR_STATUS:   s_axi_rdata <= {25'h000_0000, brake_on, op_enabled_o,
                                               motor_current_on_o, 1'b0, state_q};
                default: begin
                    if (s_axi_araddr >= ADDR_DLY_BASE && s_axi_araddr < ADDR_PWM_FREQ) begin
                        s_axi_rdata <= {16'h0000, dly_q[s_axi_araddr[3:2]]};
                    end else begin
                        s_axi_rdata <= 32'h0000_0000;
                    end
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;
endmodule

// >>> testbench/bsp_top_properties.sv
// Checker: port timing of the brake sequencer and its register bus
module bsp_chk (
    input wire logic        sys_clk_i,
    input wire logic        sys_rst_i,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        motor_current_on_o,
    input wire logic        motor_stop_req_o,
    input wire logic        op_enabled_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------
    // Sequencer order
    // ------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Enabled state needs current on and no stop request
    property p_op_cur; op_enabled_o |-> motor_current_on_o && !motor_stop_req_o; endproperty
    a_op_cur: assert property (p_op_cur) else $error("enabled without current");
    property p_stop_cur; motor_stop_req_o |-> motor_current_on_o; endproperty
    a_stop_cur: assert property (p_stop_cur) else $error("stop request without current");
    property p_rise_op; $rose(op_enabled_o) |-> $past(motor_current_on_o); endproperty
    a_rise_op: assert property (p_rise_op) else $error("enabled before current was on");
    // Past reset is excluded: a reset drops current without any engage phase
    property p_fall_cur; $fell(motor_current_on_o) && !$past(sys_rst_i) |-> $past(motor_stop_req_o); endproperty
    a_fall_cur: assert property (p_fall_cur) else $error("current off outside engage phase");
    // ------------------------------
    // Register bus handshakes
    // ------------------------------
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    property p_wr_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_wr_block: assert property (p_wr_block) else $error("write taken while response pending");
    property p_b_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write response late");
    property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_lat: assert property (p_r_lat) else $error("read data late");
endmodule

// >>> testbench/bsp_brake_model.sv
// Partner model: brake coil on the output pin, timing its on and off runs
module bsp_brake_model (
    input  wire logic        sys_clk_i,
    input  wire logic        brake_out_i,
    output logic      [31:0] hi_len_o,
    output logic      [31:0] lo_len_o,
    output logic      [31:0] hi_cnt_o,
    output logic      [31:0] lo_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        lvl_q = 1'b0;
    logic [31:0] run_q = 32'h0000_0000;
    // Counters start clear so the bench can take differences
    logic [31:0] hi_len_q = 32'h0000_0000;
    logic [31:0] lo_len_q = 32'h0000_0000;
    logic [31:0] hi_cnt_q = 32'h0000_0000;
    logic [31:0] lo_cnt_q = 32'h0000_0000;
    assign hi_len_o = hi_len_q;
    assign lo_len_o = lo_len_q;
    assign hi_cnt_o = hi_cnt_q;
    assign lo_cnt_o = lo_cnt_q;
    // A run is reported only when an edge closes it, so no partial run leaks out
    always @(posedge sys_clk_i) begin
        if (brake_out_i !== lvl_q) begin
            if (lvl_q) begin
                hi_len_q <= run_q;
                hi_cnt_q <= hi_cnt_q + 32'h0000_0001;
            end else begin
                lo_len_q <= run_q;
                lo_cnt_q <= lo_cnt_q + 32'h0000_0001;
            end
            lvl_q <= brake_out_i;
            run_q <= 32'h0000_0001;
        end else begin
            run_q <= run_q + 32'h0000_0001;
        end
    end
endmodule

// >>> testbench/testbench.sv
// Testbench: register access, brake sequencing and brake PWM of the brake sequencer
module testbench
    import bsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, motor_standstill_i = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, hi_len, lo_len, hi_cnt, lo_cnt;
    logic [31:0] base = 32'h0000_0000;
    logic        motor_current_on_o, motor_stop_req_o, op_enabled_o, brake_out_o;
    logic [4:0]  mon;
    int          fails = 0;
    int          num_checks = 0;
    // Watched levels: PWM run count, brake, enabled, stop request, current
    assign mon = {lo_cnt == base + 32'h0000_0002, brake_out_o, op_enabled_o, motor_stop_req_o, motor_current_on_o};
    always #5 sys_clk_i = ~sys_clk_i;
    bsp_top bsp_top_inst (.*);
    bsp_brake_model bsp_brake_model_inst (
        .sys_clk_i(sys_clk_i), .brake_out_i(brake_out_o), .hi_len_o(hi_len),
        .lo_len_o(lo_len), .hi_cnt_o(hi_cnt), .lo_cnt_o(lo_cnt)
    );
    // ------------------------------
    // Shared tasks
    // ------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic to_fail();
        fails++;
        $display("ERROR %0t: wait ran out", $time);
        results();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for one watched level, sampled after the edge has settled
    task automatic wait_lvl(input int b, input logic v, input int lim);
        int n;
        n = 0;
        num_checks++;
        while (mon[b] !== v) begin
            @(posedge sys_clk_i);
            #1;
            n++;
            if (n > lim) to_fail();
        end
    endtask
    // Readies are sampled mid-cycle, where they equal what the next edge sees
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_t, w_t, b_t;
        int   n;
        b_t = 1'b0;
        n = 0;
        @(posedge sys_clk_i);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!b_t) begin
            @(negedge sys_clk_i);
            aw_t = s_axi_awvalid & s_axi_awready;
            w_t  = s_axi_wvalid & s_axi_wready;
            b_t  = s_axi_bvalid === 1'b1;
            if (b_t) chk(32'(s_axi_bresp), 32'(er));
            @(posedge sys_clk_i);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
            if (b_t) s_axi_bready <= 1'b0;
            n++;
            if (n > 50) to_fail();
        end
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_t, r_t;
        int   n;
        r_t = 1'b0;
        n = 0;
        @(posedge sys_clk_i);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!r_t) begin
            @(negedge sys_clk_i);
            ar_t = s_axi_arvalid & s_axi_arready;
            r_t  = s_axi_rvalid === 1'b1;
            if (r_t) chk(s_axi_rdata, ed);
            if (r_t) chk(32'(s_axi_rresp), 32'(er));
            @(posedge sys_clk_i);
            if (ar_t) s_axi_arvalid <= 1'b0;
            if (r_t) s_axi_rready <= 1'b0;
            n++;
            if (n > 50) to_fail();
        end
    endtask
    // ------------------------------
    // Main sequence; delays stay zero so each step follows next cycle
    // ------------------------------
    initial begin
        repeat (3) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        axr(ADDR_PWM_FREQ, 32'h0000_07D0, RESP_OKAY);
        axr(ADDR_PWM_DUTY, 32'h0000_0064, RESP_OKAY);
        axr(8'h30, 32'h0000_0000, RESP_DECERR);
        axw(ADDR_STATUS, 32'h0000_00FF, RESP_DECERR);
        axr(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
        // Bad settings are dropped, the last good one stays
        axw(ADDR_PWM_FREQ, 32'h0000_03E8, RESP_OKAY);
        axw(ADDR_PWM_FREQ, 32'h0000_07D1, RESP_OKAY);
        axw(ADDR_PWM_FREQ, 32'h0000_0000, RESP_OKAY);
        axr(ADDR_PWM_FREQ, 32'h0000_03E8, RESP_OKAY);
        axw(ADDR_PWM_FREQ, 32'h0000_07D0, RESP_OKAY);
        axw(ADDR_PWM_DUTY, 32'h0000_0001, RESP_OKAY);
        axw(ADDR_PWM_DUTY, 32'h0000_0065, RESP_OKAY);
        axr(ADDR_PWM_DUTY, 32'h0000_0064, RESP_OKAY);
        // Manual mode: bit 0 alone drives the brake, 100 percent never pulses
        axw(ADDR_DOUT, 32'h0000_0001, RESP_OKAY);
        wait_lvl(3, 1'b1, 10);
        base = hi_cnt;
        repeat (300) @(posedge sys_clk_i);
        #1;
        chk(hi_cnt, base);
        chk(32'(brake_out_o), 32'h0000_0001);
        axw(ADDR_DOUT, 32'h0000_FFFE, RESP_OKAY);
        wait_lvl(3, 1'b0, 10);
        axw(ADDR_DOUT, 32'h0000_0001, RESP_OKAY);
        axw(ADDR_OVR_EN, 32'h0000_0001, RESP_OKAY);
        wait_lvl(3, 1'b0, 10);
        axw(ADDR_OVR_VAL, 32'h0000_0001, RESP_OKAY);
        wait_lvl(3, 1'b1, 10);
        axw(ADDR_OVR_VAL, 32'h0000_0000, RESP_OKAY);
        axw(ADDR_OVR_EN, 32'h0000_0000, RESP_OKAY);
        // Auto mode: brake held until operation is requested, then released in the release hold step, one cycle ahead of enabled
        axw(ADDR_SUBMODE, 32'h0000_0004, RESP_OKAY);
        wait_lvl(3, 1'b0, 10);
        axw(ADDR_DRV_CTRL, 32'h0000_0001, RESP_OKAY);
        wait_lvl(0, 1'b1, 10);
        wait_lvl(2, 1'b1, 20);
        wait_lvl(3, 1'b1, 10);
        axr(ADDR_STATUS, 32'h0000_0073, RESP_OKAY);
        // Leaving: brake stays released until the motor stands still
        axw(ADDR_DRV_CTRL, 32'h0000_0000, RESP_OKAY);
        wait_lvl(1, 1'b1, 10);
        repeat (50) @(posedge sys_clk_i);
        #1;
        chk(32'(mon[3:0]), 32'h0000_000B);
        @(posedge sys_clk_i);
        motor_standstill_i <= 1'b1;
        wait_lvl(0, 1'b0, 20);
        wait_lvl(3, 1'b0, 5);
        chk(32'(mon[3:0]), 32'h0000_0000);
        // 2000 Hz at 2 percent: 1000 cycles on, 49000 off
        axw(ADDR_SUBMODE, 32'h0000_0000, RESP_OKAY);
        axw(ADDR_DOUT, 32'h0000_0000, RESP_OKAY);
        axw(ADDR_PWM_DUTY, 32'h0000_0002, RESP_OKAY);
        axr(ADDR_PWM_DUTY, 32'h0000_0002, RESP_OKAY);
        base = lo_cnt;
        axw(ADDR_DOUT, 32'h0000_0001, RESP_OKAY);
        wait_lvl(4, 1'b1, 60000);
        chk(hi_len, 32'h0000_03E8);
        chk(lo_len, 32'h0000_BF68);
        results();
    end
endmodule
bind bsp_top bsp_chk bsp_chk_inst (.*);
